// ---- design/dvr_vbi_ctrl.v ----
// Interrupt pending flags, raw VBI capture control and the raw VBI output stream buffer.
`timescale 1ns/1ns
`include "dvr_regs.vh"

// ====================
// Synchronous FIFO with valid and ready on both sides
// ====================
module dvr_fifo #(
    parameter WIDTH = 8,                   // Word width in bits.
    parameter DEPTH = 32,                  // Number of words held.
    parameter AW    = 5                    // Pointer width, log2 of DEPTH.
) (
    input  wire             ref_clk_i,     // Pixel clock.
    input  wire             reset_n_i,     // Synchronous reset, active low.
    input  wire             in_valid_i,    // Writer offers a word.
    output wire             in_ready_o,    // FIFO can take a word.
    input  wire [WIDTH-1:0] in_data_i,     // Word offered.
    output wire             out_valid_o,   // FIFO holds a word.
    input  wire             out_ready_i,   // Reader takes the word.
    output wire [WIDTH-1:0] out_data_o     // Oldest word.
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];     // Word storage.
    reg [AW-1:0]    wr_ptr_q;              // Next write slot.
    reg [AW-1:0]    rd_ptr_q;              // Next read slot.
    reg [AW:0]      count_q;               // Words held.
    wire push = in_valid_i && in_ready_o;  // A word enters this cycle.
    wire pop  = out_valid_o && out_ready_i; // A word leaves this cycle.
    // Full and empty come straight from the occupancy count.
    assign in_ready_o  = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_ptr_q];
    // Storage write; no reset is needed on the array itself.
    always @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end
    // Pointers and occupancy count.
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// ====================
// Status and raw_vbi_capture_control block
// ====================
// Overview of operation
// - Genlock loss sets pending bit 7.
// - Signal loss sets bit 6; resets zero.
// - New caption bytes set pending bit 5.
// - New widescreen data sets pending bit 4.
// - Teletext in field sets bit 3.
// - Copy-protect status change sets bit 2.
// - Standard auto-detect success sets bit 1.
// - Each new field sets pending bit 0.
// - Host writes one to clear a bit.
// - Mask bit gates each cause's interrupt.
// - Preamble FF, count, count, 00 when enabled.
// - First count: zero, field, line high bits.
// - Second count: zeros, line low bits.
// - Bit6 even parity, bit7 its inverse.
// - Whole field or line masks select lines.
// - Even field bit enables even lines.
// - Odd field bit enables odd lines.
// - Each line mask bit enables one line.
module dvr_vbi_ctrl #(
    parameter FIFO_DEPTH      = 32,        // Raw VBI output buffer depth.
    parameter FIFO_AW         = 5,         // Log2 of the buffer depth.
    parameter MASK_FIRST_ODD  = 9,         // Line count of mask bit 0, odd field.
    parameter MASK_FIRST_EVEN = 9          // Line count of mask bit 0, even field.
) (
    input  wire        ref_clk_i,          // Pixel clock.
    input  wire        reset_n_i,          // Synchronous reset, active low.
    // Register access from the serial control interface.
    input  wire [7:0]  reg_addr_i,         // Sub-address.
    input  wire        reg_wr_i,           // Write strobe.
    input  wire [7:0]  reg_wdata_i,        // Write data.
    input  wire        reg_rd_i,           // Read strobe.
    output reg  [7:0]  reg_rdata_o,        // Read data, valid the cycle after the strobe.
    // Decoder events, one-cycle pulses except the copy-protect status.
    input  wire        genlock_lost_i,     // Genlock to the input was lost.
    input  wire        signal_lost_i,      // Input video signal was lost.
    input  wire        caption_new_i,      // Caption data registers refreshed.
    input  wire        widescreen_signalling_new_i, // Widescreen data registers refreshed.
    input  wire        teletext_seen_i,    // Teletext found in the current field.
    input  wire [2:0]  copy_protect_detect_i, // Copy-protect detection status.
    input  wire        std_detect_done_i,  // Standard auto-detect succeeded.
    input  wire        field_start_i,      // A new field begins.
    output wire        irq_o,              // Interrupt request, active high.
    // Raw VBI sample input.
    input  wire        line_start_i,       // A new video line begins.
    input  wire [8:0]  line_count_i,       // Line count within the field.
    input  wire        field_even_i,       // Current field is even.
    input  wire        samp_valid_i,       // Raw sample offered.
    output wire        samp_ready_o,       // Raw sample taken.
    input  wire [7:0]  samp_data_i,        // Raw sample.
    // Raw VBI output stream.
    output wire        vbi_valid_o,        // Stream byte available.
    input  wire        vbi_ready_i,        // Consumer takes the byte.
    output wire [7:0]  vbi_data_o          // Stream byte.
);
    // One-hot capture states.
    localparam [5:0] ST_IDLE = 6'h01;      // Line not captured.
    localparam [5:0] ST_PRE0 = 6'h02;      // Opening preamble byte.
    localparam [5:0] ST_PRE1 = 6'h04;      // First count byte.
    localparam [5:0] ST_PRE2 = 6'h08;      // Second count byte.
    localparam [5:0] ST_PRE3 = 6'h10;      // Closing preamble byte.
    localparam [5:0] ST_DATA = 6'h20;      // Raw samples pass through.
    localparam [23:0] LMASK_RST = {`DVR_RST_LMASK_HI, `DVR_RST_LMASK_MID, `DVR_RST_LMASK_LO};

    // ====================
    // Registers
    // ====================
    reg  [7:0]  irq_mask_q;                // Interrupt mask.
    reg  [7:0]  pending_q;                 // Event pending flags.
    reg  [7:0]  pending_d;                 // Next pending flags.
    reg  [7:0]  raw_ctrl_q;                // Raw VBI capture control.
    reg  [18:0] line_mask_q;               // Per-line capture enables.
    reg  [2:0]  copy_protect_prev_q;       // Copy-protect status last cycle.
    reg  [5:0]  state_q;                   // Capture state.
    reg  [5:0]  state_d;                   // Next capture state.
    reg  [8:0]  line_q;                    // Line count latched at line start.
    reg         field_q;                   // Field latched at line start.
    reg         take_line;                 // The starting line is captured.
    reg  [8:0]  mask_idx;                  // Line offset into the mask.
    reg  [7:0]  push_data;                 // Byte offered to the buffer.
    reg         push_valid;                // Byte offer valid.
    wire        push_ready;                // Buffer can take a byte.
    wire [7:0]  events;                    // Event pulses in flag order.
    wire [5:0]  cnt_high_low;              // Low six bits of the first count byte.
    wire [5:0]  cnt_low_low;               // Low six bits of the second count byte.
    wire [7:0]  preamble_count_high;       // First count byte.
    wire [7:0]  preamble_count_low;        // Second count byte.

    // Gather the event pulses into flag positions.
    assign events[`DVR_EV_GENLOCK]      = genlock_lost_i;
    assign events[`DVR_EV_SIGNAL]       = signal_lost_i;
    assign events[`DVR_EV_CAPTION]      = caption_new_i;
    assign events[`DVR_EV_WIDESCREEN]   = widescreen_signalling_new_i;
    assign events[`DVR_EV_TELETEXT]     = teletext_seen_i;
    assign events[`DVR_EV_COPY_PROTECT] =
        (copy_protect_detect_i != copy_protect_prev_q);
    assign events[`DVR_EV_STD_DETECT]   = std_detect_done_i;
    assign events[`DVR_EV_FIELD]        = field_start_i;

    // A written one clears its flag, a zero leaves it; a new event wins over a clear.
    always @* begin
        pending_d = pending_q;
        if (reg_wr_i && (reg_addr_i == `DVR_ADDR_PENDING)) begin
            pending_d = pending_q & ~reg_wdata_i;
        end
        pending_d = pending_d | events;
    end

    // Interrupt request follows any flag whose mask bit is set.
    assign irq_o = |(pending_q & irq_mask_q);

    // Register writes, flag update and copy-protect history.
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            irq_mask_q          <= `DVR_RST_IRQ_MASK;
            pending_q           <= `DVR_RST_PENDING;
            raw_ctrl_q          <= `DVR_RST_RAW_CTRL;
            line_mask_q         <= LMASK_RST[18:0];
            copy_protect_prev_q <= copy_protect_detect_i; // No false change at release.
        end else begin
            pending_q           <= pending_d;
            copy_protect_prev_q <= copy_protect_detect_i;
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `DVR_ADDR_IRQ_MASK:  irq_mask_q <= reg_wdata_i;
                    `DVR_ADDR_RAW_CTRL:  raw_ctrl_q <= reg_wdata_i & `DVR_CTL_USED_MASK;
                    `DVR_ADDR_LMASK_LO:  line_mask_q[7:0] <= reg_wdata_i;
                    `DVR_ADDR_LMASK_MID: line_mask_q[15:8] <= reg_wdata_i;
                    `DVR_ADDR_LMASK_HI:  line_mask_q[18:16] <= reg_wdata_i[2:0];
                    default:             ; // Pending writes are handled above; other sub-addresses belong to other blocks.
                endcase
            end
        end
    end

    // Registered read data; unmapped sub-addresses read zero.
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DVR_ADDR_IRQ_MASK:  reg_rdata_o <= irq_mask_q;
                `DVR_ADDR_PENDING:   reg_rdata_o <= pending_q;
                `DVR_ADDR_RAW_CTRL:  reg_rdata_o <= raw_ctrl_q;
                `DVR_ADDR_LMASK_LO:  reg_rdata_o <= line_mask_q[7:0];
                `DVR_ADDR_LMASK_MID: reg_rdata_o <= line_mask_q[15:8];
                `DVR_ADDR_LMASK_HI:  reg_rdata_o <= {5'h00, line_mask_q[18:16]};
                default:             reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ====================
    // Line selection
    // ====================
    // Decide at line start whether the line enters the raw stream.
    always @* begin
        if (field_even_i) begin
            mask_idx = line_count_i - MASK_FIRST_EVEN[8:0];
        end else begin
            mask_idx = line_count_i - MASK_FIRST_ODD[8:0];
        end
        // Each mask bit enables exactly one line of the field.
        take_line = raw_ctrl_q[`DVR_CTL_WHOLE_FIELD] ||
                    ((mask_idx < 9'd19) && line_mask_q[mask_idx[4:0]]);
        if (field_even_i) begin
            take_line = take_line && raw_ctrl_q[`DVR_CTL_EVEN_FIELD];
        end else begin
            take_line = take_line && raw_ctrl_q[`DVR_CTL_ODD_FIELD];
        end
    end

    // ====================
    // Preamble count bytes
    // ====================
    assign cnt_high_low = {1'b0, field_q, line_q[7:4]};
    assign cnt_low_low  = {2'b00, line_q[3:0]};
    assign preamble_count_high = {~(^cnt_high_low), ^cnt_high_low,
                                  cnt_high_low};
    assign preamble_count_low  = {~(^cnt_low_low), ^cnt_low_low,
                                  cnt_low_low};

    // ====================
    // Capture sequencer
    // ====================
    // Choose the byte offered to the buffer and the next state.
    always @* begin
        state_d    = state_q;
        push_valid = 1'b0;
        push_data  = samp_data_i;
        case (state_q)
            ST_IDLE: begin
                // Samples of an unselected line are dropped.
            end
            ST_PRE0: begin
                push_valid = 1'b1;
                push_data  = `DVR_PRE_FIRST;
                if (push_ready) begin
                    state_d = ST_PRE1;
                end
            end
            ST_PRE1: begin
                push_valid = 1'b1;
                push_data  = preamble_count_high;
                if (push_ready) begin
                    state_d = ST_PRE2;
                end
            end
            ST_PRE2: begin
                push_valid = 1'b1;
                push_data  = preamble_count_low;
                if (push_ready) begin
                    state_d = ST_PRE3;
                end
            end
            ST_PRE3: begin
                push_valid = 1'b1;
                push_data  = `DVR_PRE_LAST;
                if (push_ready) begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                push_valid = samp_valid_i;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // A new line restarts the sequence whatever state it finds.
        if (line_start_i) begin
            if (!take_line) begin
                state_d = ST_IDLE;
            end else if (raw_ctrl_q[`DVR_CTL_PREAMBLE]) begin
                state_d = ST_PRE0;
            end else begin
                state_d = ST_DATA;
            end
        end
    end

    // Samples stall while the preamble is being sent or the buffer is full.
    assign samp_ready_o = (state_q == ST_IDLE) || ((state_q == ST_DATA) && push_ready);

    // State and line latch.
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            line_q  <= 9'h000;
            field_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (line_start_i) begin
                line_q  <= line_count_i;
                field_q <= field_even_i;
            end
        end
    end

    // Output buffer in the stream path.
    dvr_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (push_valid && !line_start_i),
        .in_ready_o  (push_ready),
        .in_data_i   (push_data),
        .out_valid_o (vbi_valid_o),
        .out_ready_i (vbi_ready_i),
        .out_data_o  (vbi_data_o)
    );
endmodule

// ---- inc/dvr_regs.vh ----
// Register map, field positions, reset values and stream codes of the decoder status block.
`ifndef DVR_REGS_VH
`define DVR_REGS_VH

// ====================
// Register sub-addresses
// ====================
`define DVR_ADDR_IRQ_MASK     8'h0f  // Interrupt mask register.
`define DVR_ADDR_PENDING      8'h10  // Event pending flags, write one to clear.
`define DVR_ADDR_RAW_CTRL     8'h11  // Raw VBI capture control.
`define DVR_ADDR_LMASK_LO     8'h15  // Line mask bits 7..0.
`define DVR_ADDR_LMASK_MID    8'h16  // Line mask bits 15..8.
`define DVR_ADDR_LMASK_HI     8'h17  // Line mask bits 18..16.

// ====================
// Event pending flag positions
// ====================
`define DVR_EV_GENLOCK        7      // Genlock lost.
`define DVR_EV_SIGNAL         6      // Input signal lost.
`define DVR_EV_CAPTION        5      // New closed caption bytes.
`define DVR_EV_WIDESCREEN     4      // New widescreen signalling data.
`define DVR_EV_TELETEXT       3      // Teletext seen in this field.
`define DVR_EV_COPY_PROTECT   2      // Copy-protection status changed.
`define DVR_EV_STD_DETECT     1      // Video standard auto-detect done.
`define DVR_EV_FIELD          0      // New field started.

// ====================
// Raw_vbi_capture_control field positions
// ====================
`define DVR_CTL_PREAMBLE      3      // Preamble enable.
`define DVR_CTL_WHOLE_FIELD   2      // Whole field capture.
`define DVR_CTL_EVEN_FIELD    1      // Even field capture.
`define DVR_CTL_ODD_FIELD     0      // Odd field capture.
`define DVR_CTL_USED_MASK     8'h0f  // Bits 7..4 are reserved and read zero.

// ====================
// Reset values
// ====================
`define DVR_RST_IRQ_MASK      8'h00
`define DVR_RST_PENDING       8'h00
`define DVR_RST_RAW_CTRL      8'h00
`define DVR_RST_LMASK_LO      8'hfe
`define DVR_RST_LMASK_MID     8'h1f
`define DVR_RST_LMASK_HI      8'h00
`define DVR_LMASK_HI_USED     8'h07  // Bits 7..3 of the high mask are reserved.

// ====================
// Preamble byte values
// ====================
`define DVR_PRE_FIRST         8'hff  // Opening byte of a line preamble.
`define DVR_PRE_LAST          8'h00  // Closing byte of a line preamble.

`endif

// ---- test/dvr_vbi_ctrl_checker.sv ----
// Port-level assertions of the status and raw_vbi_capture_control block.
`timescale 1ns/1ns
// ====================
// Checker
// ====================
module dvr_vbi_ctrl_checker (
    input wire       ref_clk_i,      // Pixel clock.
    input wire       reset_n_i,      // Reset, active low.
    input wire [7:0] reg_addr_i,     // Sub-address.
    input wire       reg_wr_i,       // Write strobe.
    input wire [7:0] reg_wdata_i,    // Write data.
    input wire       reg_rd_i,       // Read strobe.
    input wire [7:0] reg_rdata_o,    // Read data.
    input wire       genlock_lost_i, // Genlock loss event.
    input wire       irq_o,          // Interrupt request.
    input wire       vbi_valid_o,    // Stream byte valid.
    input wire       vbi_ready_i,    // Stream consumer ready.
    input wire [7:0] vbi_data_o      // Stream byte.
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Read data stands between reads.
    property p_rd_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    // Control reads back its low nibble, reserved bits zero.
    property p_ctrl_rb; (reg_wr_i && reg_addr_i == 8'h11) ##1 !reg_wr_i ##1 (reg_rd_i
        && reg_addr_i == 8'h11) |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h0f); endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
    // A pending request only drops through a write.
    property p_irq_hold; irq_o && !reg_wr_i |=> irq_o; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_irq_fall; $fell(irq_o) |-> $past(reg_wr_i); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    // Unmasked genlock loss raises the request next cycle.
    property p_gl_irq; (reg_wr_i && reg_addr_i == 8'h0f && reg_wdata_i[7]) ##1 !reg_wr_i
        ##1 (genlock_lost_i && !reg_wr_i) |=> irq_o; endproperty
    a_gl_irq: assert property (p_gl_irq) else $error("genlock irq missing");
    property p_mask_off; reg_wr_i && reg_addr_i == 8'h0f && reg_wdata_i == 8'h00 |=> !irq_o;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq active");
    // A stalled stream byte holds.
    property p_vbi_hold; vbi_valid_o && !vbi_ready_i |=> vbi_valid_o && $stable(vbi_data_o);
    endproperty
    a_vbi_hold: assert property (p_vbi_hold) else $error("stream byte not held");
    // Outputs come out of reset idle.
    property p_rst_out; $rose(reset_n_i) |-> reg_rdata_o == 8'h00 && !irq_o && !vbi_valid_o;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not idle at reset");
    c_irq: cover property ($rose(irq_o));
    c_xfer: cover property (vbi_valid_o && vbi_ready_i);
    c_stall: cover property (vbi_valid_o && !vbi_ready_i ##1 vbi_ready_i);
endmodule
bind dvr_vbi_ctrl dvr_vbi_ctrl_checker u_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .genlock_lost_i(genlock_lost_i),
    .irq_o(irq_o), .vbi_valid_o(vbi_valid_o), .vbi_ready_i(vbi_ready_i),
    .vbi_data_o(vbi_data_o));

// ---- test/dvr_host_model.sv ----
// Host controller model issuing register accesses.
`timescale 1ns/1ns
// ====================
// Host model
// ====================
module dvr_host_model (
    input  wire       ref_clk_i, // Pixel clock.
    input  wire [7:0] rdata_i,   // Read data.
    output reg  [7:0] addr_o,    // Sub-address.
    output reg        wr_o,      // Write strobe.
    output reg  [7:0] wdata_o,   // Write data.
    output reg        rd_o       // Read strobe.
);
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    // Write; a pending bit is cleared only by a one. Released lines flip.
    task wr(input [7:0] a, input [7:0] d);
        begin
            addr_o = a;
            wdata_o = d;
            wr_o = 1'b1;
            @(posedge ref_clk_i);
            #1 wr_o = 1'b0;
            addr_o = ~addr_o;
            wdata_o = ~wdata_o;
            @(posedge ref_clk_i);
            #1;
        end
    endtask
    // Read; data is taken the cycle after the strobe edge.
    task rd(input [7:0] a, output [7:0] d);
        begin
            addr_o = a;
            rd_o = 1'b1;
            @(posedge ref_clk_i);
            #1 d = rdata_i;
            rd_o = 1'b0;
            addr_o = ~addr_o;
            @(posedge ref_clk_i);
            #1;
        end
    endtask
endmodule

// ---- test/tb_dvr_vbi_ctrl.sv ----
// Self-checking bench for the status and raw_vbi_capture_control block.
`timescale 1ns/1ns
`include "dvr_regs.vh"
// ====================
// Bench top
// ====================
module tb_dvr_vbi_ctrl;
    reg        ref_clk_i = 1'b0;    // Pixel clock.
    reg        reset_n_i = 1'b0;    // Reset, active low.
    reg  [7:0] ev        = 8'h00;   // Event pulses by pending bit.
    reg  [2:0] cp        = 3'h0;    // Copy-protect status level.
    reg        lstart    = 1'b0;    // Line start.
    reg  [8:0] lcnt      = 9'h000;  // Line count.
    reg        feven     = 1'b0;    // Even field.
    reg        svalid    = 1'b0;    // Sample offered.
    reg  [7:0] sdata     = 8'h00;   // Sample.
    reg        vready    = 1'b0;    // Consumer ready.
    wire [7:0] addr, wdata, rdata, vdata;
    wire       wr, rd, irq, sready, vvalid;
    integer    err_total = 0;       // Mismatches.
    integer    samples_checked = 0; // Comparisons.
    reg  [7:0] q[$];                // Expected stream bytes.
    reg  [7:0] rv;                  // Last read value.
    integer    i;
    always #5 ref_clk_i = ~ref_clk_i;
    dvr_vbi_ctrl u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .genlock_lost_i(ev[7]), .signal_lost_i(ev[6]), .caption_new_i(ev[5]),
        .widescreen_signalling_new_i(ev[4]), .teletext_seen_i(ev[3]),
        .copy_protect_detect_i(cp), .std_detect_done_i(ev[1]), .field_start_i(ev[0]),
        .irq_o(irq), .line_start_i(lstart), .line_count_i(lcnt), .field_even_i(feven),
        .samp_valid_i(svalid), .samp_ready_o(sready), .samp_data_i(sdata),
        .vbi_valid_o(vvalid), .vbi_ready_i(vready), .vbi_data_o(vdata));
    dvr_host_model u_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
        .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
    task chk(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            u_host.rd(a, rv);
            chk(rv, exp);
        end
    endtask
    // Count byte: bit 6 even parity of bits 5..0, bit 7 its inverse.
    function [7:0] cnt(input [5:0] b);
        cnt = {~^b, ^b, b};
    endfunction
    // Raises one cause; bit 2 is a copy-protect level change.
    task pulse(input integer b);
        begin
            if (b == 2) cp = cp + 3'h1;
            else ev = 8'h01 << b;
            @(posedge ref_clk_i);
            #1 ev = 8'h00;
        end
    endtask
    task t_events;
        begin
            u_host.wr(`DVR_ADDR_IRQ_MASK, 8'hff);
            for (i = 7; i >= 0; i = i - 1) begin
                pulse(i);
                chk({7'h0, irq}, 8'h01);
                rdc(`DVR_ADDR_PENDING, 8'h01 << i);
                u_host.wr(`DVR_ADDR_PENDING, ~(8'h01 << i));
                rdc(`DVR_ADDR_PENDING, 8'h01 << i);
                u_host.wr(`DVR_ADDR_PENDING, 8'h01 << i);
                rdc(`DVR_ADDR_PENDING, 8'h00);
                chk({7'h0, irq}, 8'h00);
            end
            u_host.wr(`DVR_ADDR_IRQ_MASK, 8'h01);
            pulse(7);
            chk({7'h0, irq}, 8'h00);
            u_host.wr(`DVR_ADDR_IRQ_MASK, 8'h80);
            chk({7'h0, irq}, 8'h01);
            u_host.wr(`DVR_ADDR_IRQ_MASK, 8'h00);
            chk({7'h0, irq}, 8'h00);
            u_host.wr(`DVR_ADDR_IRQ_MASK, 8'h80);
            chk({7'h0, irq}, 8'h01);
            u_host.wr(`DVR_ADDR_PENDING, 8'h80);
            chk({7'h0, irq}, 8'h00);
        end
    endtask
    // One line: sends n samples with the consumer stalled, then drains.
    task t_line(input [7:0] ctl, input [8:0] ln, input even, input sel, input integer n);
        integer k;
        integer j;
        begin
            u_host.wr(`DVR_ADDR_RAW_CTRL, ctl);
            lcnt = ln;
            feven = even;
            lstart = 1'b1;
            @(posedge ref_clk_i);
            #1 lstart = 1'b0;
            if (sel && ctl[3]) begin
                q.push_back(`DVR_PRE_FIRST);
                q.push_back(cnt({1'b0, even, ln[7:4]}));
                q.push_back(cnt({2'b00, ln[3:0]}));
                q.push_back(`DVR_PRE_LAST);
            end
            for (k = 0; k < n; k = k + 1) begin
                svalid = 1'b1;
                sdata = 8'h30 + k[7:0];
                if (sel) q.push_back(sdata);
                for (j = 0; j < 40 && sready !== 1'b1; j = j + 1) begin
                    @(posedge ref_clk_i);
                    #1;
                end
                @(posedge ref_clk_i);
                #1;
            end
            svalid = 1'b0;
            if (q.size() == 32) chk({7'h0, sready}, 8'h00);
            vready = 1'b1;
            while (q.size() > 0) begin
                for (j = 0; j < 20 && vvalid !== 1'b1; j = j + 1) begin
                    @(posedge ref_clk_i);
                    #1;
                end
                chk(vdata ^ {7'h0, ~vvalid}, q.pop_front());
                @(posedge ref_clk_i);
                #1;
            end
            vready = 1'b0;
            chk({7'h0, vvalid}, 8'h00);
        end
    endtask
    task print_verdict;
        begin
            if (err_total == 0 && samples_checked > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    initial begin
        #100000 err_total = err_total + 1;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        #1 reset_n_i = 1'b1;
        rdc(`DVR_ADDR_IRQ_MASK, `DVR_RST_IRQ_MASK);
        rdc(`DVR_ADDR_PENDING, `DVR_RST_PENDING);
        rdc(`DVR_ADDR_RAW_CTRL, `DVR_RST_RAW_CTRL);
        rdc(`DVR_ADDR_LMASK_LO, `DVR_RST_LMASK_LO);
        rdc(`DVR_ADDR_LMASK_MID, `DVR_RST_LMASK_MID);
        rdc(`DVR_ADDR_LMASK_HI, `DVR_RST_LMASK_HI);
        rdc(8'h20, 8'h00);
        t_events;
        u_host.wr(`DVR_ADDR_RAW_CTRL, 8'hff);
        rdc(`DVR_ADDR_RAW_CTRL, 8'h0f);
        t_line(8'h09, 9'h015, 1'b0, 1'b1, 3);
        t_line(8'h0e, 9'h0a7, 1'b1, 1'b1, 2);
        t_line(8'h06, 9'h015, 1'b0, 1'b0, 3);
        t_line(8'h01, 9'h015, 1'b1, 1'b0, 2);
        t_line(8'h02, 9'h009, 1'b1, 1'b0, 2);
        t_line(8'h0a, 9'h00a, 1'b1, 1'b1, 2);
        t_line(8'h01, 9'h01b, 1'b0, 1'b0, 2);
        u_host.wr(`DVR_ADDR_LMASK_HI, 8'hff);
        rdc(`DVR_ADDR_LMASK_HI, 8'h07);
        t_line(8'h01, 9'h01b, 1'b0, 1'b1, 2);
        t_line(8'h05, 9'h014, 1'b0, 1'b1, 32);
        print_verdict;
    end
endmodule
